// ### accc_core.sv
// Purpose: Configuration, calibration and I/O control of the converter
// Assumes: Register port is byte-wide, single-cycle, synchronous
// Notes:   Analog settings leave as decoded control outputs
//
// How it works
// - Buffer on only when pin and control bit are both set.
// - Two current sources, each an 8-bit code plus range field.
// - Current scale is code times two to range minus one; range zero is off.
// - Three-bit gain field selects gains one to 128 in powers of two.
// - Offset trim is sign-magnitude: top bit sign, seven bits magnitude.
// - Modulator tick is master clock over 128 or 256 by speed bit.
// - Reference enable bit and level bit drive the reference outputs.
// - Three self-calibration commands: both, gain only, offset only.
// - Single calibrations take seven data periods, combined takes fourteen.
// - System offset calibration, host applies zero input, seven periods.
// - System gain calibration, host applies full-scale input.
// - Ready output falls when calibration finishes.
// - Fast, sinc2, sinc3 filters or an automatic mode.
// - Auto mode: two fast conversions, one sinc2, then sinc3.
// - Eight general I/O pins come up as inputs.
// - Direction bit per pin; value register sets driven level.
// - Input pins read back their level through a two-stage synchroniser.
// - Device is serial slave only, never drives the clock.
// - Back-to-back accesses accepted without idle gaps.
// - Clock polarity taken from the polarity pin.
// - Ready rises after a data read and before result update.
`timescale 1ns/10ps
`default_nettype none
module accc_core
  import accc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       buffer_enable_pin_i,
  input  wire logic       sclk_polarity_pin_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [3:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  input  wire logic       cal_start_i,
  input  wire logic [2:0] cal_cmd_i,
  input  wire logic       data_read_i,
  input  wire logic       gpio_value_i_i,
  input  wire logic [7:0] gpio_pin_i,
  output logic      [7:0] gpio_pin_o,
  output logic      [7:0] gpio_pin_oe_o,
  output logic            buffer_on_o,
  output logic            ref_on_o,
  output logic            internal_vref_level_o,
  output logic      [7:0] current_source_a_o,
  output logic      [7:0] current_source_b_o,
  output logic      [3:0] src_a_scale_o,
  output logic      [3:0] src_b_scale_o,
  output logic      [7:0] gain_o,
  output logic            offset_trim_neg_o,
  output logic      [6:0] offset_trim_mag_o,
  output logic            modulator_rate_o,
  output logic      [1:0] filter_o,
  output logic            cal_busy_o,
  output logic      [2:0] cal_kind_o,
  output logic            sclk_idle_high_o,
  output logic            result_ready_n_o
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    CAL_IDLE = 2'b01,
    CAL_RUN  = 2'b10
  } accc_cal_st_t;

  typedef struct packed {
    logic [7:0]   setup;
    logic [7:0]   mux;
    logic [7:0]   analog_control_reg;
    logic [7:0]   src_a;
    logic [7:0]   src_b;
    logic [7:0]   trim;
    logic [7:0]   gpio;
    logic [7:0]   dir;
    logic [7:0]   decl;
    logic [7:0]   mdec;
    logic [7:0]   sync1;
    logic [7:0]   sync2;
    logic [10:0]  dcnt;
    logic         dtick;
    accc_cal_st_t cal;
    logic [4:0]   cal_left;
    logic [2:0]   cal_kind;
    logic         rdy_n;
    logic [7:0]   rdata;
    logic         restart;
  } accc_st_t;

  accc_st_t st_r;
  accc_st_t st_nxt;

  accc_sync_if sif ();

  accc_mod_div u_div (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .sif   (sif)
  );

  accc_filt_seq u_seq (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .sif   (sif)
  );

  assign sif.speed     = st_r.setup[ACCC_SPEED_BIT];
  assign sif.data_tick = st_r.dtick;
  assign sif.restart   = st_r.restart;
  assign sif.smode     = st_r.mdec[ACCC_MDEC_SM_LSB +: 2];

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Range code 0 is treated as off; 1..3 scale by 1, 2, 4
  function automatic logic [3:0] accc_range_scale(input logic [1:0] rng);
    accc_range_scale = (rng == 2'h0) ? 4'h0 : 4'(4'h1 << (rng - 2'h1));
  endfunction : accc_range_scale

  function automatic logic [10:0] accc_dec_ratio(input logic [7:0] lo, input logic [7:0] hi);
    accc_dec_ratio = {hi[2:0], lo};
  endfunction : accc_dec_ratio

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    logic [10:0] ratio;
    logic [7:0]  pin_rd;
    ratio  = accc_dec_ratio(st_r.decl, st_r.mdec);
    pin_rd = (st_r.dir & st_r.sync2) | (~st_r.dir & st_r.gpio);
    st_nxt = st_r;
    st_nxt.dtick   = 1'b0;
    st_nxt.restart = 1'b0;

    // Synchroniser: first stage feeds only the second
    st_nxt.sync1 = gpio_pin_i;
    st_nxt.sync2 = st_r.sync1;

    // Conversion period from modulator ticks and decimation ratio
    if (sif.mod_tick) begin
      if (st_r.dcnt >= ratio - 11'h001 || ratio == 11'h000) begin
        st_nxt.dcnt  = 11'h000;
        st_nxt.dtick = 1'b1;
      end else begin
        st_nxt.dcnt = st_r.dcnt + 11'h001;
      end
    end

    // Register writes, back to back allowed
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        ACCC_SETUP_IDX: st_nxt.setup = {ACCC_ID_CODE, reg_wdata_i[4:0]};
        ACCC_MUX_IDX: begin
          st_nxt.mux = reg_wdata_i;
          st_nxt.restart = (reg_wdata_i != st_r.mux);
        end
        ACCC_ACR_IDX: begin
          st_nxt.analog_control_reg = reg_wdata_i;
          st_nxt.restart = (reg_wdata_i[2:0] != st_r.analog_control_reg[2:0]);
        end
        ACCC_SRC_A_IDX: st_nxt.src_a = reg_wdata_i;
        ACCC_SRC_B_IDX: st_nxt.src_b = reg_wdata_i;
        ACCC_TRIM_IDX:  st_nxt.trim  = reg_wdata_i;
        ACCC_GPIO_IDX:  st_nxt.gpio  = reg_wdata_i;
        ACCC_DIR_IDX:   st_nxt.dir   = reg_wdata_i;
        ACCC_DECL_IDX:  st_nxt.decl  = reg_wdata_i;
        ACCC_MDEC_IDX: begin
          st_nxt.mdec = {st_r.mdec[ACCC_MDEC_RDY], reg_wdata_i[6:4], 1'b0, reg_wdata_i[2:0]};
        end
        default: ;
      endcase
    end

    // Read data, registered
    unique case (reg_addr_i)
      ACCC_SETUP_IDX: st_nxt.rdata = st_r.setup;
      ACCC_MUX_IDX:   st_nxt.rdata = st_r.mux;
      ACCC_ACR_IDX:   st_nxt.rdata = st_r.analog_control_reg;
      ACCC_SRC_A_IDX: st_nxt.rdata = st_r.src_a;
      ACCC_SRC_B_IDX: st_nxt.rdata = st_r.src_b;
      ACCC_TRIM_IDX:  st_nxt.rdata = st_r.trim;
      ACCC_GPIO_IDX:  st_nxt.rdata = pin_rd;
      ACCC_DIR_IDX:   st_nxt.rdata = st_r.dir;
      ACCC_DECL_IDX:  st_nxt.rdata = st_r.decl;
      ACCC_MDEC_IDX:  st_nxt.rdata = {st_r.rdy_n, st_r.mdec[6:0]};
      default:        st_nxt.rdata = ACCC_ZERO_RST;
    endcase
    if (!reg_rd_i) begin
      st_nxt.rdata = st_r.rdata;
    end

    // Calibration sequencer
    unique case (st_r.cal)
      CAL_IDLE: begin
        if (cal_start_i && cal_cmd_i <= 3'(ACCC_CAL_SYS_GAIN)) begin
          st_nxt.cal      = CAL_RUN;
          st_nxt.cal_kind = cal_cmd_i;
          st_nxt.cal_left = (cal_cmd_i == 3'(ACCC_CAL_SELF_BOTH)) ? ACCC_CAL_BOTH : ACCC_CAL_ONE;
          st_nxt.rdy_n    = 1'b1;
        end
      end
      CAL_RUN: begin
        if (st_r.dtick) begin
          st_nxt.cal_left = st_r.cal_left - 5'h01;
          if (st_r.cal_left == 5'h01) begin
            st_nxt.cal = CAL_IDLE;
          end
        end
      end
      default: st_nxt.cal = CAL_IDLE;
    endcase

    // Ready flag: falls on new data or calibration end, rises on read
    if (st_r.cal == CAL_IDLE && st_nxt.cal == CAL_IDLE) begin
      if (data_read_i) begin
        st_nxt.rdy_n = 1'b1;
      end
      if (sif.mod_tick && st_r.dcnt == ratio - 11'h002) begin
        st_nxt.rdy_n = 1'b1;
      end
      if (st_r.dtick) begin
        st_nxt.rdy_n = 1'b0; // New data wins over a read in the same cycle
      end
    end
    if (st_r.cal == CAL_RUN && st_r.dtick && st_r.cal_left == 5'h01) begin
      st_nxt.rdy_n = 1'b0;
    end
    st_nxt.mdec[ACCC_MDEC_RDY] = st_nxt.rdy_n;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r          <= '0;
      st_r.setup    <= {ACCC_ID_CODE, ACCC_SETUP_RST[4:0]};
      st_r.mux      <= ACCC_MUX_RST;
      st_r.dir      <= 8'hff;
      st_r.decl     <= ACCC_DECL_RST;
      st_r.mdec     <= ACCC_MDEC_RST;
      st_r.cal      <= CAL_IDLE;
      st_r.rdy_n    <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign reg_rdata_o           = st_r.rdata;
  assign gpio_pin_o            = st_r.gpio;
  assign gpio_pin_oe_o         = ~st_r.dir;
  assign buffer_on_o           = buffer_enable_pin_i & st_r.setup[ACCC_BUFFER_ENABLE_PIN_BIT];
  assign ref_on_o              = st_r.setup[ACCC_REFEN_BIT];
  assign internal_vref_level_o = st_r.setup[ACCC_REFHI_BIT];
  assign current_source_a_o    = st_r.src_a;
  assign current_source_b_o    = st_r.src_b;
  assign src_a_scale_o         = accc_range_scale(st_r.analog_control_reg[ACCC_ACR_A_LSB +: 2]);
  assign src_b_scale_o         = accc_range_scale(st_r.analog_control_reg[ACCC_ACR_B_LSB +: 2]);
  assign gain_o                = 8'(8'h01 << st_r.analog_control_reg[2:0]);
  assign offset_trim_neg_o     = st_r.trim[7];
  assign offset_trim_mag_o     = st_r.trim[6:0];
  assign modulator_rate_o      = sif.mod_tick;
  assign filter_o              = 2'(sif.active_flt);
  assign cal_busy_o            = (st_r.cal == CAL_RUN);
  assign cal_kind_o            = st_r.cal_kind;
  assign sclk_idle_high_o      = ~sclk_polarity_pin_i;
  assign result_ready_n_o      = st_r.rdy_n;

  // gpio_value_i_i is unused spare strap
  logic unused_w;
  assign unused_w = gpio_value_i_i;
endmodule : accc_core
`default_nettype wire

// ### accc_core_asserts.sv
// Purpose: Port-level checks of the converter control core
// Assumes: One clock, synchronous active-high reset
// Notes:   Tick spacing tracked by a small gap counter
`timescale 1ns/10ps
`default_nettype none
module accc_core_asserts (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       buffer_enable_pin_i,
  input wire logic       sclk_polarity_pin_i,
  input wire logic       cal_start_i,
  input wire logic [2:0] cal_cmd_i,
  input wire logic [7:0] gpio_pin_oe_o,
  input wire logic       buffer_on_o,
  input wire logic [7:0] gain_o,
  input wire logic       modulator_rate_o,
  input wire logic       cal_busy_o,
  input wire logic       sclk_idle_high_o,
  input wire logic       result_ready_n_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Saturates so a stalled divider still trips the bound
  logic [8:0] gap_r;
  always_ff @(posedge clk_i) begin
    if (rst_i || modulator_rate_o) gap_r <= 9'h000;
    else if (gap_r != 9'h1ff) gap_r <= gap_r + 9'h001;
  end

  property p_buf; !buffer_enable_pin_i |-> !buffer_on_o; endproperty
  a_buf: assert property (p_buf) else $error("buffer on without pin");
  property p_gain; $onehot(gain_o); endproperty
  a_gain: assert property (p_gain) else $error("gain not a power of two");
  property p_idle; sclk_idle_high_o == !sclk_polarity_pin_i; endproperty
  a_idle: assert property (p_idle) else $error("clock idle sense wrong");
  property p_gap; modulator_rate_o |-> gap_r >= 9'h07e && gap_r <= 9'h0ff; endproperty
  a_gap: assert property (p_gap) else $error("modulator tick spacing");
  property p_cal_go;
    cal_start_i && !cal_busy_o && cal_cmd_i <= 3'h4 |=> cal_busy_o && result_ready_n_o;
  endproperty
  a_cal_go: assert property (p_cal_go) else $error("calibration not started");
  property p_cal_bad; cal_start_i && !cal_busy_o && cal_cmd_i > 3'h4 |=> !cal_busy_o; endproperty
  a_cal_bad: assert property (p_cal_bad) else $error("bad command started");
  property p_cal_done; $fell(cal_busy_o) |-> !result_ready_n_o; endproperty
  a_cal_done: assert property (p_cal_done) else $error("ready not low at end");
  property p_busy_min; $rose(cal_busy_o) |-> cal_busy_o [*8]; endproperty
  a_busy_min: assert property (p_busy_min) else $error("calibration too short");
  property p_rst_vals; $fell(rst_i) |-> gpio_pin_oe_o == 8'h00 && result_ready_n_o; endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("pins not inputs at reset");

  c_done: cover property ($fell(cal_busy_o));
  c_tick: cover property (modulator_rate_o ##1 !modulator_rate_o);
  c_buf: cover property (buffer_on_o);
endmodule : accc_core_asserts
`default_nettype wire

// ### accc_core_tb_top.sv
// Purpose: Self-checking bench for the converter control core
// Assumes: Host model owns the register and command port
// Notes:   Conversion ratio of four keeps calibrations short
`timescale 1ns/10ps
`default_nettype none
module accc_core_tb_top;
  import accc_pkg::*;
  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       buf_pin = 1'b0;
  logic       pol_pin = 1'b0;
  logic [7:0] ext = 8'h00;
  logic [7:0] pins, rdata, wdata, pin_o, oe, src_a, src_b, gain;
  logic [3:0] addr, sc_a, sc_b;
  logic [6:0] mag;
  logic [2:0] cmd, kind;
  logic [1:0] filt;
  logic       wr, rd, start, ack, buf_on, ref_on, vref, neg, tick, busy, idle, rdy_n;
  int         bad_count = 0;
  int         comparisons = 0;

  assign pins = (pin_o & oe) | (ext & ~oe);
  accc_host_model host (.clk_i, .rdata_i(rdata), .wr_o(wr), .rd_o(rd), .addr_o(addr),
    .wdata_o(wdata), .start_o(start), .cmd_o(cmd), .ack_o(ack));
  accc_core dut (.clk_i, .rst_i, .buffer_enable_pin_i(buf_pin), .sclk_polarity_pin_i(pol_pin),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .cal_start_i(start), .cal_cmd_i(cmd), .data_read_i(ack), .gpio_value_i_i(1'b0),
    .gpio_pin_i(pins), .gpio_pin_o(pin_o), .gpio_pin_oe_o(oe), .buffer_on_o(buf_on),
    .ref_on_o(ref_on), .internal_vref_level_o(vref), .current_source_a_o(src_a),
    .current_source_b_o(src_b), .src_a_scale_o(sc_a), .src_b_scale_o(sc_b), .gain_o(gain),
    .offset_trim_neg_o(neg), .offset_trim_mag_o(mag), .modulator_rate_o(tick),
    .filter_o(filt), .cal_busy_o(busy), .cal_kind_o(kind), .sclk_idle_high_o(idle),
    .result_ready_n_o(rdy_n));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic settle();
    repeat (2) @(negedge clk_i);
  endtask : settle
  function automatic logic [7:0] scale(input logic [1:0] r);
    return (r == 2'h0) ? 8'h00 : 8'h01 << (r - 2'h1);
  endfunction : scale
  task automatic summarize();
    if (bad_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] d;
    logic [3:0] a [7] = '{ACCC_SETUP_IDX, ACCC_MUX_IDX, ACCC_DIR_IDX, ACCC_DECL_IDX,
                          ACCC_MDEC_IDX, ACCC_TRIM_IDX, 4'ha};
    logic [7:0] e [7] = '{8'h0e, 8'h01, 8'hff, 8'h80, 8'h80, 8'h00, 8'h00};
    settle();
    chk(oe, 8'h00, "pins not inputs");
    host.wr(4'ha, 8'h5a);
    for (int i = 0; i < 7; i++) begin
      host.rd(a[i], d);
      chk(d, e[i], "reset value");
    end
  endtask : t_reset

  task automatic t_setup();
    logic [2:0] i;
    for (int k = 0; k < 8; k++) begin
      i = 3'(k);
      @(posedge clk_i);
      buf_pin <= i[0];
      pol_pin <= i[2];
      host.wr(ACCC_SETUP_IDX, {4'h0, i[1], i[2], i[1], 1'b0});
      settle();
      chk(8'(buf_on), 8'(i[0] & i[1]), "buffer");
      chk({ref_on, vref, idle}, {5'h0, i[1], i[2], ~i[2]}, "reference");
    end
  endtask : t_setup

  task automatic t_analog();
    logic [2:0] g;
    for (int k = 0; k < 8; k++) begin
      g = 3'(k);
      host.wr(ACCC_ACR_IDX, {1'b0, ~g[1:0], g[1:0], g});
      host.wr(ACCC_SRC_A_IDX, {5'h10, g});
      host.wr(ACCC_SRC_B_IDX, 8'h01 << g);
      host.wr(ACCC_TRIM_IDX, {g[0], g, 4'h9});
      settle();
      chk(src_a, {5'h10, g}, "source a");
      chk(src_b, 8'h01 << g, "source b");
      chk({4'h0, sc_a}, scale(g[1:0]), "scale a");
      chk({4'h0, sc_b}, scale(~g[1:0]), "scale b");
      chk(gain, 8'h01 << g, "gain");
      chk({neg, mag}, {g[0], g, 4'h9}, "offset trim");
    end
  endtask : t_analog

  task automatic tick_gap(output int n);
    @(negedge clk_i);
    for (int k = 0; k < 600 && tick !== 1'b1; k++) @(negedge clk_i);
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (tick !== 1'b1 && n < 600);
  endtask : tick_gap

  task automatic t_rate();
    int n;
    for (int s = 0; s < 2; s++) begin
      host.wr(ACCC_SETUP_IDX, {3'h0, 1'(s), 4'h0});
      tick_gap(n);
      tick_gap(n);
      chk(8'(n == 128 * (s + 1)), 8'h01, "modulator divide");
    end
    host.wr(ACCC_SETUP_IDX, 8'h00);
  endtask : t_rate

  task automatic t_gpio();
    logic [7:0] d;
    host.wr(ACCC_GPIO_IDX, 8'ha5);
    host.wr(ACCC_DIR_IDX, 8'hf0);
    settle();
    chk(oe, 8'h0f, "direction");
    chk(pin_o & 8'h0f, 8'h05, "driven level");
    @(posedge clk_i);
    ext <= 8'h3c;
    host.rd(ACCC_GPIO_IDX, d);
    chk(d & 8'hf0, 8'h00, "input seen too early");
    host.rd(ACCC_GPIO_IDX, d);
    chk(d & 8'hf0, 8'h30, "input level");
  endtask : t_gpio

  task automatic t_cal();
    int n;
    int w;
    host.wr(ACCC_DECL_IDX, 8'h04);
    host.wr(ACCC_MDEC_IDX, 8'h00);
    for (int c = 0; c < 6; c++) begin
      w = (c == 0) ? 56 : 28;
      tick_gap(n);
      host.cal(3'(c));
      settle();
      chk(8'(busy), 8'(c < 5), "calibration start");
      if (c == 0) begin
        host.cal(3'h1);
        settle();
        chk({5'h0, kind}, 8'h00, "start while busy taken");
      end
      n = 0;
      for (int k = 0; k < 20000 && busy === 1'b1; k++) begin
        @(negedge clk_i);
        n += int'(tick === 1'b1);
      end
      if (c < 5) begin
        chk({5'h0, kind}, 8'(c), "calibration kind");
        chk(8'(n + 3 >= w && n <= w + 1), 8'h01, "calibration length");
        chk(8'(rdy_n), 8'h00, "ready after calibration");
        host.ack();
        settle();
        chk(8'(rdy_n), 8'h01, "ready after data read");
      end
    end
  endtask : t_cal

  task automatic watch(input logic [1:0] f, output int n);
    n = 0;
    for (int k = 0; k < 9000 && filt === f; k++) begin
      @(negedge clk_i);
      n += int'(tick === 1'b1);
    end
  endtask : watch

  task automatic t_filter();
    int n;
    host.wr(ACCC_MUX_IDX, 8'h23);
    settle();
    chk({6'h0, filt}, 8'h01, "fast after change");
    watch(2'h1, n);
    chk({6'h0, filt}, 8'h02, "sinc2 after fast");
    chk(8'(n >= 4 && n <= 8), 8'h01, "fast length");
    watch(2'h2, n);
    chk({6'h0, filt}, 8'h03, "sinc3 after sinc2");
    chk(8'(n), 8'h04, "sinc2 length");
    for (int m = 1; m < 4; m++) begin
      host.wr(ACCC_MDEC_IDX, {2'h0, 2'(m), 4'h0});
      settle();
      chk({6'h0, filt}, 8'(m), "forced filter");
    end
  endtask : t_filter

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_setup();
    t_analog();
    t_rate();
    t_gpio();
    t_cal();
    t_filter();
    summarize();
  end

  // Whole run needs some 30k cycles
  initial begin
    #300000;
    bad_count++;
    summarize();
  end
endmodule : accc_core_tb_top

bind accc_core accc_core_asserts u_chk (.clk_i, .rst_i, .buffer_enable_pin_i,
  .sclk_polarity_pin_i, .cal_start_i, .cal_cmd_i, .gpio_pin_oe_o, .buffer_on_o, .gain_o,
  .modulator_rate_o, .cal_busy_o, .sclk_idle_high_o, .result_ready_n_o);
`default_nettype wire

// ### accc_filt_seq.sv
// Purpose: Digital filter selection and automatic sequencing
// Assumes: data_tick marks the end of each conversion
// Notes:   Restart pulses on channel or gain change
`timescale 1ns/10ps
`default_nettype none
module accc_filt_seq
  import accc_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  accc_sync_if.seq  sif
);
  typedef enum logic [2:0] {
    SQ_FAST  = 3'b001,
    SQ_SINC2 = 3'b010,
    SQ_SINC3 = 3'b100
  } accc_sq_t;

  typedef struct packed {
    accc_sq_t   sq;
    logic [1:0] n;
  } accc_seq_st_t;

  accc_seq_st_t st_r;
  accc_seq_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (sif.restart) begin
      st_nxt.sq = SQ_FAST;
      st_nxt.n  = 2'h0;
    end else if (sif.data_tick) begin
      unique case (st_r.sq)
        SQ_FAST: begin
          if (st_r.n == ACCC_FAST_CNT - 2'h1) begin
            st_nxt.sq = SQ_SINC2;
          end else begin
            st_nxt.n = st_r.n + 2'h1;
          end
        end
        SQ_SINC2: st_nxt.sq = SQ_SINC3;
        SQ_SINC3: st_nxt.sq = SQ_SINC3;
        default:  st_nxt.sq = SQ_SINC3;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '{sq: SQ_FAST, n: 2'h0};
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    if (sif.smode != 2'(ACCC_FLT_AUTO)) begin
      sif.active_flt = accc_flt_t'(sif.smode);
    end else begin
      unique case (st_r.sq)
        SQ_FAST:  sif.active_flt = ACCC_FLT_FAST;
        SQ_SINC2: sif.active_flt = ACCC_FLT_SINC2;
        default:  sif.active_flt = ACCC_FLT_SINC3;
      endcase
    end
  end
endmodule : accc_filt_seq
`default_nettype wire

// ### accc_host_model.sv
// Purpose: Host model driving the register and command port
// Assumes: Requests launch just after clk_i rises
// Notes:   Released data lines carry the inverse of the last value
`timescale 1ns/10ps
`default_nettype none
module accc_host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output logic            wr_o,
  output logic            rd_o,
  output logic      [3:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            start_o,
  output logic      [2:0] cmd_o,
  output logic            ack_o
);
  initial {wr_o, rd_o, addr_o, wdata_o, start_o, cmd_o, ack_o} = '0;

  // Zero or full-scale input is applied off-chip before a system cal
  task automatic cal(input logic [2:0] c);
    @(posedge clk_i);
    start_o <= 1'b1;
    cmd_o   <= c;
    @(posedge clk_i);
    start_o <= 1'b0;
    cmd_o   <= ~c;
  endtask : cal

  // Select line is taken as tied low, one idle cycle between bytes
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_o    <= 1'b1;
    addr_o  <= a;
    wdata_o <= d;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    wdata_o <= ~d;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_i);
    rd_o   <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    rd_o   <= 1'b0;
    @(negedge clk_i);
    d = rdata_i;
  endtask : rd

  // Pulses the data read strobe for one cycle
  task automatic ack();
    @(posedge clk_i);
    ack_o <= 1'b1;
    @(posedge clk_i);
    ack_o <= 1'b0;
  endtask : ack
endmodule : accc_host_model
`default_nettype wire

// ### accc_mod_div.sv
// Purpose: Modulator rate divider producing a one-cycle enable
// Assumes: Speed bit may change at any time
// Notes:   Count restarts when it passes the new terminal value
`timescale 1ns/10ps
`default_nettype none
module accc_mod_div
  import accc_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  accc_sync_if.div  sif
);
  typedef struct packed {
    logic [8:0] cnt;
    logic       tick;
  } accc_div_st_t;

  accc_div_st_t st_r;
  accc_div_st_t st_nxt;

  always_comb begin
    logic [8:0] lim;
    lim    = sif.speed ? ACCC_DIV_SLOW : ACCC_DIV_FAST;
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (st_r.cnt >= lim - 9'h001) begin
      st_nxt.cnt  = 9'h000;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 9'h001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sif.mod_tick = st_r.tick;
endmodule : accc_mod_div
`default_nettype wire

// ### accc_pkg.sv
// Purpose: Shared constants and types for the converter control core
// Assumes: One 250 MHz clock, synchronous active-high reset
// Notes:   Register indices follow the byte-wide register bank
package accc_pkg;

  // ------------------------------------------------------------
  // Register indices
  // ------------------------------------------------------------
  localparam logic [3:0] ACCC_SETUP_IDX   = 4'h0;
  localparam logic [3:0] ACCC_MUX_IDX     = 4'h1;
  localparam logic [3:0] ACCC_ACR_IDX     = 4'h2;
  localparam logic [3:0] ACCC_SRC_A_IDX   = 4'h3;
  localparam logic [3:0] ACCC_SRC_B_IDX   = 4'h4;
  localparam logic [3:0] ACCC_TRIM_IDX    = 4'h5;
  localparam logic [3:0] ACCC_GPIO_IDX    = 4'h6;
  localparam logic [3:0] ACCC_DIR_IDX     = 4'h7;
  localparam logic [3:0] ACCC_DECL_IDX    = 4'h8;
  localparam logic [3:0] ACCC_MDEC_IDX    = 4'h9;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int ACCC_SPEED_BIT   = 4;
  localparam int ACCC_REFEN_BIT   = 3;
  localparam int ACCC_REFHI_BIT   = 2;
  localparam int ACCC_BUFFER_ENABLE_PIN_BIT   = 1;
  localparam int ACCC_ACR_A_LSB   = 3;
  localparam int ACCC_ACR_B_LSB   = 5;
  localparam int ACCC_MDEC_RDY    = 7;
  localparam int ACCC_MDEC_SM_LSB = 4;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] ACCC_SETUP_RST = 8'h0e;
  localparam logic [7:0] ACCC_MUX_RST   = 8'h01;
  localparam logic [7:0] ACCC_ZERO_RST  = 8'h00;
  localparam logic [7:0] ACCC_DECL_RST  = 8'h80;
  localparam logic [7:0] ACCC_MDEC_RST  = 8'h80;
  localparam logic [2:0] ACCC_ID_CODE   = 3'h0; // Arbitrary value

  // ------------------------------------------------------------
  // Timing counts
  // ------------------------------------------------------------
  localparam logic [8:0] ACCC_DIV_SLOW  = 9'h100;
  localparam logic [8:0] ACCC_DIV_FAST  = 9'h080;
  localparam logic [4:0] ACCC_CAL_ONE   = 5'h07;
  localparam logic [4:0] ACCC_CAL_BOTH  = 5'h0e;
  localparam logic [1:0] ACCC_FAST_CNT  = 2'h2;

  // ------------------------------------------------------------
  // Commands and modes
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ACCC_CAL_SELF_BOTH = 3'h0,
    ACCC_CAL_SELF_GAIN = 3'h1,
    ACCC_CAL_SELF_OFFS = 3'h2,
    ACCC_CAL_SYS_OFFS  = 3'h3,
    ACCC_CAL_SYS_GAIN  = 3'h4
  } accc_cal_t;

  typedef enum logic [1:0] {
    ACCC_FLT_AUTO  = 2'h0,
    ACCC_FLT_FAST  = 2'h1,
    ACCC_FLT_SINC2 = 2'h2,
    ACCC_FLT_SINC3 = 2'h3
  } accc_flt_t;

endpackage : accc_pkg

// ### accc_sync_if.sv
// Purpose: Carrier between the top and its helper modules
// Assumes: Single clock domain
// Notes:   Holds timing strobes and filter selection
`timescale 1ns/10ps
`default_nettype none
interface accc_sync_if;
  import accc_pkg::*;
  logic      speed;
  logic      mod_tick;
  logic      data_tick;
  logic      restart;
  logic [1:0] smode;
  accc_flt_t active_flt;
  modport div (input speed, output mod_tick);
  modport seq (input data_tick, input restart, input smode, output active_flt);
  modport top (output speed, input mod_tick, output data_tick, output restart,
               output smode, input active_flt);
endinterface : accc_sync_if
`default_nettype wire
